// [include/fls_pkg.sv]
// ---------------------------------------------
// shared constants and types
// ---------------------------------------------
package fls_pkg;
    // command codes, low byte only
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STAT = 8'h70;
    localparam logic [7:0] CMD_CLR_STAT = 8'h50;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_BLK_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_ALL = 8'ha7;
    localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
    localparam logic [7:0] CMD_LOCK_READ = 8'h71;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    // address map: block index in the upper bits
    localparam int ADDR_W = 16;
    localparam int BLK_SHIFT = 12;
    localparam int BLK_W = 4;
    localparam int NUM_BLK = 16;
    localparam logic [BLK_W-1:0] EA_LAST = 4'hc;
    localparam logic [NUM_BLK-1:0] LOCK_RST = 16'hffff;
    // status byte bit positions
    localparam int ST_READY = 7;
    localparam int ST_ERASE = 5;
    localparam int ST_PROG = 4;
    // array operation kinds
    typedef enum logic [1:0] {OP_PROG, OP_ERASE, OP_LOCK} fls_op_t;
    // sequencer states
    typedef enum logic [2:0] {S_IDLE, S_SECOND, S_BUSY, S_EASCAN, S_LKRD} fls_state_t;
    // one command write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
    } fls_bus_t;
    // request to the array engine
    typedef struct packed {
        fls_op_t op;
        logic [BLK_W-1:0] blk;
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
    } fls_req_t;
endpackage : fls_pkg

// [verilog/fls_sequencer.sv]
`timescale 1ns/10ps
// What this block does
// - lock-program confirm at block top locks it
// - ready low only during long commands
// - lock-status read loads lock result
// - locked block rejects program and erase
// - lock bit set only by erase
// - lock disable unlocks all, keeps bits
// - disabled lock erase ignores lock, unlocks
// - status byte on even read after 70h
// - status byte reads until read array or lock-status read
// - status byte layout ready, erase, program
// - clear status zeroes both error flags
// - errors pending refuse program/erase/lock-program commands
// - failed operation sets its error flags
// - bad second cycle sets both flags
// - read array in second cycle aborts, except after program
// - erase errors: locked or failed erase
// - program errors: locked, failed, lock fail
// - no lock errors while lock disabled
// - read array code returns flash contents
// - program code then data starts program
// - block erase confirm starts erase
// - erase all skips blocks 13 to 15
module fls_sequencer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_wr,
    input wire fls_pkg::fls_bus_t cmd,
    input wire logic rd_req,
    input wire logic [fls_pkg::ADDR_W-1:0] rd_addr,
    output logic [15:0] rd_data,
    output logic rd_valid,
    input wire logic [15:0] arr_rdata,
    output fls_pkg::fls_req_t arr_req,
    output logic arr_start,
    input wire logic arr_done,
    input wire logic arr_fail,
    input wire logic lock_disable_ctl,
    input wire logic cpu_rewrite_mode0,
    output logic seq_ready_flag,
    output logic erase_error_flag,
    output logic program_error_flag,
    output logic lock_state_result,
    output logic [7:0] flash_status_byte
);
    // ---------------------------------------------
    // state
    // ---------------------------------------------
    typedef struct packed {
        fls_pkg::fls_state_t state;     // sequencer phase
        logic [7:0] cmd1;               // first-cycle code
        logic [fls_pkg::ADDR_W-1:0] addr1; // first-cycle address
        logic [fls_pkg::NUM_BLK-1:0] lock_bits; // 0 locked
        logic ers_err;                  // erase error flag
        logic prg_err;                  // program error flag
        logic status_mode;              // reads return status
        logic lock_res;                 // lock-status result
        logic ea_active;                // erase-all in progress
        logic [fls_pkg::BLK_W-1:0] ea_blk; // erase-all cursor
        fls_pkg::fls_req_t req;         // array request
        logic start;                    // array start pulse
        logic [15:0] rd_data;           // read data
        logic rd_valid;                 // read answer
    } fls_regs_t;

    fls_regs_t s;
    fls_regs_t next_s;
    logic [7:0] code;                   // decoded low byte
    logic cmd_blk_locked;               // effective lock of cmd block

    // block index of an address
    function automatic logic [fls_pkg::BLK_W-1:0] blk_of(input logic [fls_pkg::ADDR_W-1:0] a);
        blk_of = a[fls_pkg::BLK_SHIFT +: fls_pkg::BLK_W];
    endfunction : blk_of

    // effective lock: disable control overrides stored bit
    function automatic logic eff_locked(input logic [fls_pkg::NUM_BLK-1:0] bits,
                                        input logic [fls_pkg::BLK_W-1:0] b,
                                        input logic dis);
        eff_locked = !dis && !bits[b];
    endfunction : eff_locked

    assign code = cmd.data[7:0];
    assign cmd_blk_locked = eff_locked(s.lock_bits, blk_of(cmd.addr), lock_disable_ctl);
    // ready while no long command runs
    assign seq_ready_flag = (s.state == fls_pkg::S_IDLE) || (s.state == fls_pkg::S_SECOND);
    assign erase_error_flag = s.ers_err;
    assign program_error_flag = s.prg_err;
    assign lock_state_result = s.lock_res;
    // status byte, reserved bits zero
    always_comb begin
        flash_status_byte = 8'h00;
        flash_status_byte[fls_pkg::ST_READY] = seq_ready_flag;
        flash_status_byte[fls_pkg::ST_ERASE] = s.ers_err;
        flash_status_byte[fls_pkg::ST_PROG] = s.prg_err;
    end
    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign arr_req = s.req;
    assign arr_start = s.start;

    // ---------------------------------------------
    // next-state logic
    // ---------------------------------------------
    always_comb begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.rd_valid = 1'b0;
        // reads: status byte or array word
        if (rd_req) begin
            next_s.rd_valid = 1'b1;
            if (cpu_rewrite_mode0 && s.status_mode && !rd_addr[0]) begin
                next_s.rd_data = {8'h00, flash_status_byte};
            end else begin
                next_s.rd_data = arr_rdata;
            end
        end
        unique case (s.state)
            fls_pkg::S_IDLE: begin
                // first bus cycle
                if (cmd_wr) begin
                    unique case (code)
                        fls_pkg::CMD_READ_ARRAY: next_s.status_mode = 1'b0;
                        fls_pkg::CMD_READ_STAT: next_s.status_mode = 1'b1;
                        fls_pkg::CMD_CLR_STAT: begin
                            next_s.ers_err = 1'b0;
                            next_s.prg_err = 1'b0;
                        end
                        fls_pkg::CMD_PROGRAM, fls_pkg::CMD_BLK_ERASE,
                        fls_pkg::CMD_ERASE_ALL, fls_pkg::CMD_LOCK_PROG: begin
                            // refused while an error is pending
                            if (!s.ers_err && !s.prg_err) begin
                                next_s.state = fls_pkg::S_SECOND;
                                next_s.cmd1 = code;
                                next_s.addr1 = cmd.addr;
                            end
                        end
                        fls_pkg::CMD_LOCK_READ: begin
                            next_s.state = fls_pkg::S_SECOND;
                            next_s.cmd1 = code;
                            next_s.addr1 = cmd.addr;
                        end
                        default: begin
                            next_s.ers_err = 1'b1;
                            next_s.prg_err = 1'b1;
                        end
                    endcase
                end
            end
            fls_pkg::S_SECOND: begin
                // second bus cycle
                if (cmd_wr) begin
                    next_s.state = fls_pkg::S_IDLE;
                    next_s.req.addr = cmd.addr;
                    next_s.req.data = cmd.data;
                    next_s.req.blk = blk_of(cmd.addr);
                    if (s.cmd1 == fls_pkg::CMD_PROGRAM) begin
                        next_s.status_mode = 1'b1;
                        if (cmd_blk_locked) begin
                            next_s.prg_err = 1'b1;
                        end else begin
                            next_s.req.op = fls_pkg::OP_PROG;
                            next_s.start = 1'b1;
                            next_s.state = fls_pkg::S_BUSY;
                        end
                    end else if (code == fls_pkg::CMD_READ_ARRAY) begin
                        next_s.status_mode = 1'b0;
                    end else if (code != fls_pkg::CMD_CONFIRM) begin
                        next_s.ers_err = 1'b1;
                        next_s.prg_err = 1'b1;
                    end else begin
                        unique case (s.cmd1)
                            fls_pkg::CMD_BLK_ERASE: begin
                                next_s.status_mode = 1'b1;
                                if (cmd_blk_locked) begin
                                    next_s.ers_err = 1'b1;
                                end else begin
                                    next_s.req.op = fls_pkg::OP_ERASE;
                                    next_s.start = 1'b1;
                                    next_s.state = fls_pkg::S_BUSY;
                                end
                            end
                            fls_pkg::CMD_ERASE_ALL: begin
                                next_s.status_mode = 1'b1;
                                next_s.ea_active = 1'b1;
                                next_s.ea_blk = '0;
                                next_s.state = fls_pkg::S_EASCAN;
                            end
                            fls_pkg::CMD_LOCK_PROG: begin
                                next_s.status_mode = 1'b1;
                                next_s.req.op = fls_pkg::OP_LOCK;
                                next_s.start = 1'b1;
                                next_s.state = fls_pkg::S_BUSY;
                            end
                            default: begin
                                // lock-status read leaves status mode
                                next_s.status_mode = 1'b0;
                                next_s.state = fls_pkg::S_LKRD;
                            end
                        endcase
                    end
                end
            end
            fls_pkg::S_LKRD: begin
                // one busy cycle, then result
                next_s.lock_res = s.lock_bits[s.req.blk];
                next_s.state = fls_pkg::S_IDLE;
            end
            fls_pkg::S_EASCAN: begin
                // walk blocks 0..12, skipping locked ones
                if (s.ea_blk > fls_pkg::EA_LAST) begin
                    next_s.ea_active = 1'b0;
                    next_s.state = fls_pkg::S_IDLE;
                end else if (eff_locked(s.lock_bits, s.ea_blk, lock_disable_ctl)) begin
                    next_s.ea_blk = s.ea_blk + 4'h1;
                end else begin
                    next_s.req.op = fls_pkg::OP_ERASE;
                    next_s.req.blk = s.ea_blk;
                    next_s.req.addr = {s.ea_blk, {fls_pkg::BLK_SHIFT{1'b0}}};
                    next_s.start = 1'b1;
                    next_s.state = fls_pkg::S_BUSY;
                end
            end
            fls_pkg::S_BUSY: begin
                // commands ignored until the array answers
                if (arr_done) begin
                    next_s.state = fls_pkg::S_IDLE;
                    if (arr_fail) begin
                        next_s.ea_active = 1'b0;
                        if (s.req.op == fls_pkg::OP_ERASE) begin
                            next_s.ers_err = 1'b1;
                        end else begin
                            next_s.prg_err = 1'b1;
                        end
                    end else if (s.req.op == fls_pkg::OP_ERASE) begin
                        next_s.lock_bits[s.req.blk] = 1'b1;
                        if (s.ea_active) begin
                            next_s.ea_blk = s.ea_blk + 4'h1;
                            next_s.state = fls_pkg::S_EASCAN;
                        end
                    end else if (s.req.op == fls_pkg::OP_LOCK) begin
                        next_s.lock_bits[s.req.blk] = 1'b0;
                    end
                end
            end
            default: next_s.state = fls_pkg::S_IDLE;
        endcase
    end

    // ---------------------------------------------
    // state register
    // ---------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s <= '0;
            s.state <= fls_pkg::S_IDLE;
            s.lock_bits <= fls_pkg::LOCK_RST;
        end else begin
            s <= next_s;
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    property p_lock_prog;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_BUSY && s.req.op == fls_pkg::OP_LOCK && arr_done && !arr_fail)
        |=> !s.lock_bits[$past(s.req.blk)] && seq_ready_flag;
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock bit not cleared");

    property p_lock_read;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_SECOND && cmd_wr && s.cmd1 == fls_pkg::CMD_LOCK_READ
         && code == fls_pkg::CMD_CONFIRM)
        |=> !seq_ready_flag ##1 seq_ready_flag && lock_state_result == s.lock_bits[s.req.blk];
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read timing wrong");

    property p_no_set;
        @(posedge clk) disable iff (!resetn)
        ((s.lock_bits & ~$past(s.lock_bits)) != '0)
        |-> $past(s.state == fls_pkg::S_BUSY && s.req.op == fls_pkg::OP_ERASE && arr_done);
    endproperty
    a_no_set: assert property (p_no_set) else $error("lock bit set without erase");

    property p_locked_prog;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_SECOND && cmd_wr && s.cmd1 == fls_pkg::CMD_PROGRAM)
        |=> program_error_flag == $past(cmd_blk_locked) && !erase_error_flag
            && arr_start == !program_error_flag;
    endproperty
    a_locked_prog: assert property (p_locked_prog) else $error("program lock check");

    property p_clear;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_IDLE && cmd_wr && code == fls_pkg::CMD_CLR_STAT)
        |=> !erase_error_flag && !program_error_flag && flash_status_byte[5:4] == 2'b00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear status failed");

    property p_refuse;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_IDLE && cmd_wr && (s.ers_err || s.prg_err)
         && (code == fls_pkg::CMD_PROGRAM || code == fls_pkg::CMD_BLK_ERASE
             || code == fls_pkg::CMD_ERASE_ALL || code == fls_pkg::CMD_LOCK_PROG))
        |=> s.state == fls_pkg::S_IDLE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command taken with error");

    property p_seq_err;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_SECOND && cmd_wr && s.cmd1 == fls_pkg::CMD_BLK_ERASE
         && code != fls_pkg::CMD_CONFIRM && code != fls_pkg::CMD_READ_ARRAY)
        |=> erase_error_flag && program_error_flag && !arr_start;
    endproperty
    a_seq_err: assert property (p_seq_err) else $error("sequence error missing");

    property p_abort;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_SECOND && cmd_wr && s.cmd1 != fls_pkg::CMD_PROGRAM
         && code == fls_pkg::CMD_READ_ARRAY)
        |=> s.state == fls_pkg::S_IDLE && !s.status_mode && !arr_start;
    endproperty
    a_abort: assert property (p_abort) else $error("read array abort failed");

    property p_status_rd;
        @(posedge clk) disable iff (!resetn)
        (rd_req && cpu_rewrite_mode0 && s.status_mode && !rd_addr[0])
        |=> rd_valid && rd_data == {8'h00, $past(flash_status_byte)};
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status byte not returned");

    property p_busy_ign;
        @(posedge clk) disable iff (!resetn)
        (s.state == fls_pkg::S_BUSY && !arr_done) |=> $stable(s.lock_bits) && !seq_ready_flag;
    endproperty
    a_busy_ign: assert property (p_busy_ign) else $error("busy state disturbed");
endmodule : fls_sequencer

// [tb/fls_array_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// array engine stand-in
// ----------------------------------------
module fls_array_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic arr_start,
    input wire logic [fls_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [7:0] delay,
    input wire logic fail_next,
    output logic [15:0] arr_rdata,
    output logic arr_done,
    output logic arr_fail
);
    // countdown, busy and done pulse
    typedef struct packed {
        logic [7:0] cnt;
        logic busy;
        logic done;
        logic fail;
    } fls_mdl_st_t;
    fls_mdl_st_t st;
    fls_mdl_st_t next_st;
    // array word is a pattern of its address
    assign arr_rdata = rd_addr ^ 16'h5a5a;
    assign arr_done = st.done;
    // fail is only meaningful with done
    assign arr_fail = st.done ? st.fail : ~st.fail;
    // one done per start, delay+1 cycles later (at least two)
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (arr_start) begin
            next_st.cnt = delay;
            next_st.busy = 1'b1;
            next_st.fail = fail_next;
        end else if (st.busy && st.cnt <= 8'h01) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
        end else if (st.busy) begin
            next_st.cnt = st.cnt - 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : fls_array_model

// [tb/flash_lock_status_sequencer_tb.sv]
`timescale 1ns/10ps
module flash_lock_status_sequencer_tb;
    logic clk, resetn, cmd_wr, rd_req, lock_disable_ctl, cpu_rewrite_mode0;
    fls_pkg::fls_bus_t cmd;
    fls_pkg::fls_req_t arr_req;
    logic [15:0] rd_addr, rd_data, arr_rdata, seen_blk, lk;
    logic rd_valid, arr_start, arr_done, arr_fail, seq_ready_flag, fail_next;
    logic erase_error_flag, program_error_flag, lock_state_result;
    logic [7:0] flash_status_byte, delay;
    int n_mismatch, n_checks, n_start;
    // ----------------------------------------
    // design, array model, clock, monitor
    // ----------------------------------------
    fls_sequencer dut (.clk(clk), .resetn(resetn), .cmd_wr(cmd_wr), .cmd(cmd),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .arr_rdata(arr_rdata), .arr_req(arr_req), .arr_start(arr_start),
        .arr_done(arr_done), .arr_fail(arr_fail), .lock_disable_ctl(lock_disable_ctl),
        .cpu_rewrite_mode0(cpu_rewrite_mode0), .seq_ready_flag(seq_ready_flag),
        .erase_error_flag(erase_error_flag), .program_error_flag(program_error_flag),
        .lock_state_result(lock_state_result), .flash_status_byte(flash_status_byte));
    fls_array_model mdl (.clk(clk), .resetn(resetn), .arr_start(arr_start),
        .rd_addr(rd_addr), .delay(delay), .fail_next(fail_next), .arr_rdata(arr_rdata),
        .arr_done(arr_done), .arr_fail(arr_fail));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count array starts and their blocks
    always @(negedge clk) begin
        if (arr_start === 1'b1) begin
            n_start++;
            seen_blk[arr_req.blk] = 1'b1;
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string w);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp, input string w);
        chk_word({15'h0, got}, {15'h0, exp}, w);
    endtask : chk_bit
    // command word with a random upper byte
    function automatic logic [15:0] cw(input logic [7:0] c);
        return {8'($urandom), c};
    endfunction : cw
    function automatic logic [15:0] blk_top(input logic [3:0] b);
        return {b, 12'hffe};
    endfunction : blk_top
    // expected {start, erase err, program err}; op 0 program, 1 erase, 2 lock
    function automatic logic [2:0] exp_op(input int op, input logic lkb, input logic fl);
        if (op == 2) return 3'b100;
        if (!lkb) return (op == 0) ? 3'b001 : 3'b010;
        if (fl) return (op == 0) ? 3'b101 : 3'b110;
        return 3'b100;
    endfunction : exp_op
    task automatic cmd1(input logic [15:0] d);
        @(negedge clk);
        cmd_wr = 1'b1;
        cmd = {16'h8000, d};
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd = ~cmd;
    endtask : cmd1
    task automatic cmd2(input logic [15:0] a, input logic [15:0] d1, input logic [15:0] d2);
        @(negedge clk);
        cmd_wr = 1'b1;
        cmd = {a, d1};
        @(negedge clk);
        cmd = {a, d2};
        @(negedge clk);
        cmd_wr = 1'b0;
        cmd = ~cmd;
    endtask : cmd2
    task automatic wait_ready;
        int i;
        for (i = 0; i < 1000 && seq_ready_flag !== 1'b1; i++) @(negedge clk);
        if (i == 1000) begin
            n_mismatch++;
            $display("Error %0t ready never returned", $time);
            give_verdict();
        end
    endtask : wait_ready
    task automatic chk_err(input logic [1:0] ef);
        chk_word({14'h0, erase_error_flag, program_error_flag}, {14'h0, ef}, "flags");
        chk_word({8'h0, flash_status_byte}, {8'h0, 2'b10, ef, 4'h0}, "status");
    endtask : chk_err
    task automatic run(input logic [15:0] a, input logic [7:0] c1, input logic [15:0] d2,
                       input logic fl, input logic go, input logic [1:0] ef);
        int s;
        fail_next = fl;
        delay = 8'($urandom_range(1, 20));
        s = n_start;
        cmd2(a, cw(c1), d2);
        chk_bit(seq_ready_flag, !go, "ready in op");
        wait_ready();
        chk_word(16'(n_start - s), {15'h0, go}, "starts");
        chk_err(ef);
        if (go) chk_word(arr_req.addr, a, "array address");
        if (go && c1 == fls_pkg::CMD_PROGRAM) chk_word(arr_req.data, d2, "program data");
    endtask : run
    task automatic lkrd(input logic [3:0] b, input logic exp);
        cmd2(blk_top(b), cw(fls_pkg::CMD_LOCK_READ), cw(fls_pkg::CMD_CONFIRM));
        chk_bit(seq_ready_flag, 1'b0, "ready in lock read");
        wait_ready();
        chk_bit(lock_state_result, exp, "lock state");
    endtask : lkrd
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_req = 1'b0;
        rd_addr = ~a;
        chk_bit(rd_valid, 1'b1, "read valid");
        chk_word(rd_data, exp, "read data");
    endtask : rd
    task automatic clr;
        cmd1(cw(fls_pkg::CMD_CLR_STAT));
        chk_err(2'b00);
    endtask : clr
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] codes [3];
        logic [15:0] cf, wd;
        logic [12:0] lkpre;
        logic [3:0] b;
        logic [2:0] e;
        logic fl;
        int op, s;
        codes = '{fls_pkg::CMD_PROGRAM, fls_pkg::CMD_BLK_ERASE, fls_pkg::CMD_LOCK_PROG};
        cf = {8'h00, fls_pkg::CMD_CONFIRM};
        {resetn, cmd_wr, rd_req, lock_disable_ctl, fail_next} = '0;
        cpu_rewrite_mode0 = 1'b1;
        cmd = '0;
        rd_addr = '0;
        delay = 8'h01;
        {n_mismatch, n_checks, n_start} = '0;
        seen_blk = '0;
        lk = 16'hffff;
        void'($urandom(32'hfc785071));
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        chk_bit(seq_ready_flag, 1'b1, "ready after reset");
        chk_err(2'b00);
        run(blk_top(3), codes[2], cw(cf[7:0]), 1'b0, 1'b1, 2'b00);
        chk_word({14'h0, arr_req.op}, {14'h0, fls_pkg::OP_LOCK}, "op");
        lk[3] = 1'b0;
        lkrd(3, 1'b0);
        lkrd(4, 1'b1);
        run(16'h3010, codes[0], 16'($urandom), 1'b0, 1'b0, 2'b01);
        rd(16'h3010, 16'h0090);
        rd(16'h3011, 16'h3011 ^ 16'h5a5a);
        run(blk_top(5), codes[1], cw(fls_pkg::CMD_READ_ARRAY), 1'b0, 1'b0, 2'b01);
        clr();
        run(blk_top(3), codes[1], cf, 1'b0, 1'b0, 2'b10);
        clr();
        $display("lock protection test done");
        lock_disable_ctl = 1'b1;
        run(16'h3020, codes[0], 16'($urandom), 1'b0, 1'b1, 2'b00);
        lock_disable_ctl = 1'b0;
        lkrd(3, 1'b0);
        lock_disable_ctl = 1'b1;
        run(blk_top(3), codes[1], cf, 1'b0, 1'b1, 2'b00);
        lock_disable_ctl = 1'b0;
        lk[3] = 1'b1;
        lkrd(3, 1'b1);
        $display("lock disable test done");
        run(16'h5000, codes[0], 16'($urandom), 1'b1, 1'b1, 2'b01);
        clr();
        run(blk_top(5), codes[1], cf, 1'b1, 1'b1, 2'b10);
        clr();
        run(blk_top(14), codes[2], cf, 1'b1, 1'b1, 2'b01);
        clr();
        run(blk_top(14), codes[2], cf, 1'b0, 1'b1, 2'b00);
        lk[14] = 1'b0;
        run(blk_top(6), codes[1], 16'h1255, 1'b0, 1'b0, 2'b11);
        clr();
        run(blk_top(6), codes[2], 16'h0055, 1'b0, 1'b0, 2'b11);
        clr();
        cmd1(cw(8'h33));
        chk_err(2'b11);
        clr();
        run(blk_top(6), fls_pkg::CMD_ERASE_ALL, cw(8'hff), 1'b0, 1'b0, 2'b00);
        rd(16'h6000, 16'h6000 ^ 16'h5a5a);
        $display("error report test done");
        cmd1(cw(fls_pkg::CMD_READ_STAT));
        rd(16'h8000, 16'h0080);
        cpu_rewrite_mode0 = 1'b0;
        rd(16'h8000, 16'h8000 ^ 16'h5a5a);
        cpu_rewrite_mode0 = 1'b1;
        cmd1(cw(fls_pkg::CMD_READ_ARRAY));
        rd(16'h8002, 16'h8002 ^ 16'h5a5a);
        fail_next = 1'b0;
        delay = 8'd30;
        cmd2(16'h9000, cw(codes[0]), 16'($urandom));
        cmd1(cw(codes[2]));
        wait_ready();
        lkrd(9, 1'b1);
        chk_err(2'b00);
        $display("status and busy test done");
        for (int k = 0; k < 12; k++) begin
            op = $urandom_range(0, 2);
            b = 4'($urandom);
            fl = (op == 0) && ($urandom_range(0, 1) == 1);
            e = exp_op(op, lk[b], fl);
            wd = (op == 0) ? 16'($urandom) : cf;
            run({b, 11'($urandom), 1'b0}, codes[op], wd, fl, e[2], e[1:0]);
            if (e[2] && !fl && op != 0) lk[b] = (op == 1);
            clr();
        end
        $display("random test done");
        lkpre = lk[12:0];
        seen_blk = '0;
        s = n_start;
        fail_next = 1'b0;
        delay = 8'h02;
        cmd2(16'h0000, cw(fls_pkg::CMD_ERASE_ALL), cw(fls_pkg::CMD_CONFIRM));
        chk_bit(seq_ready_flag, 1'b0, "ready in erase all");
        wait_ready();
        chk_word(16'(n_start - s), 16'($countones(lkpre)), "erase all starts");
        chk_word(seen_blk, {3'h0, lkpre}, "erased blocks");
        chk_err(2'b00);
        $display("erase all test done");
        give_verdict();
    end
endmodule : flash_lock_status_sequencer_tb
